// *** bdmd_input_detect.sv ***
// Input detection front end: phase mux, comparator control, D event filter.
// Assumes the analog comparator output is asynchronous and gets synchronised
// here; commutation, sample ticks and configuration come from the same clock.
// Overview of operation
// RL1 - Speed input type 00 gives sensor or sensorless mode, else speed sensor
// RL2 - Sensor mode flag picks sensor/sensorless; 01,10,11 mean speed sensor
// RL3 - Speed sensor uses phases as digital levels; sensor mode yields Hall bits
// RL4 - Phase input select routes phase A, B or C to the comparator
// RL5 - Comparator stays off until clock enable or reference converter set
// RL6 - Threshold code picks internal level; all ones picks external pin
// RL7 - Zero-cross sampling at window rate in current mode, PWM in voltage
// RL8 - Demag sampling uses the filter sample tick, independent of PWM
// RL9 - Autoswitched hard commutation orders commutation, demag, zero crossing
// RL10 - Zero crossing accepted only after demag seen since commutation
// RL11 - Edge polarity and same-edge select classify sampled comparator output
// RL12 - Sensorless blanking after commutation ignores demag for field time
// RL13 - Blanking starts after hardware and software commutation
// RL14 - Codes 0-7 give 5-40 us, codes 8-15 give 60-200 us
// RL15 - Sensor mode flag set means no blanking window
// RL16 - After blanking count consecutive demag samples, flag at limit
// RL17 - Count field n requires n plus one consecutive events
// RL18 - Reset gives count limit one and longest blanking window
// RL19 - Counter only for hardware demag; simulated demag counts as one
// RL20 - A non-matching sample restarts the consecutive count at zero
module bdmd_input_detect
	import bdmd_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Phase pins and comparator
	input  wire logic       phase_input_a_in,
	input  wire logic       phase_input_b_in,
	input  wire logic       phase_input_c_in,
	input  wire logic       comp_out_in,
	// Mode configuration
	input  wire logic       sensor_mode_flag_in,
	input  wire logic [1:0] speed_input_type_in,
	input  wire logic       current_mode_in,
	input  wire logic       hard_comm_in,
	input  wire logic       comp_clk_en_in,
	input  wire logic       ref_dac_en_in,
	input  wire logic [1:0] phase_input_select_in,
	input  wire logic [2:0] threshold_select_in,
	input  wire logic       edge_polarity_bit_in,
	input  wire logic       same_edge_select_in,
	// Demag filter configuration, loaded on strobe
	input  wire logic       demag_filter_wr_in,
	input  wire logic [3:0] demag_blank_window_in,
	input  wire logic [3:0] demag_count_limit_in,
	// Events and ticks
	input  wire logic       comm_hw_in,
	input  wire logic       comm_sw_in,
	input  wire logic       demag_sim_in,
	input  wire logic       filter_sample_tick_in,
	input  wire logic       meas_window_tick_in,
	input  wire logic       pwm_u_tick_in,
	// Comparator control
	output logic [1:0]      comp_mux_sel_out,
	output logic            comp_enable_out,
	output logic [2:0]      comp_int_level_out,
	output logic            comp_ext_ref_out,
	// Status
	output logic            speed_sensor_mode_out,
	output logic            sensor_mode_out,
	output logic [2:0]      hall_out,
	output logic [2:0]      digital_in_out,
	output logic            demag_flag_out,
	output logic            zero_cross_out
);
	logic        comp_s;
	logic [2:0]  ph_s;
	logic [3:0]  blank_code;
	logic [3:0]  cnt_limit;
	logic [3:0]  next_blank_code;
	logic [3:0]  next_cnt_limit;
	bdmd_state_e state;
	bdmd_state_e next_state;
	logic [BLANK_W-1:0] blank_cnt;
	logic [BLANK_W-1:0] next_blank_cnt;
	logic [4:0]  ev_cnt;
	logic [4:0]  next_ev_cnt;
	logic        next_demag;
	logic        next_zc;
	logic        comm;
	logic        demag_match;
	logic        zc_match;
	logic        zc_tick;
	logic        hall_mode;

	// Blanking length in core cycles, scaled from microseconds
	function automatic logic [BLANK_W-1:0] blank_cycles(input logic [3:0] code);
		int us;
		us = 0;
		if (!code[3])
			us = (int'(code[2:0]) + 1) * BLANK_STEP_LO_US; // RL14
		else
			us = BLANK_BASE_HI_US + int'(code[2:0]) * BLANK_STEP_HI_US; // RL14
		return BLANK_W'(us * CYC_PER_US);
	endfunction

	bdmd_sync u_sync_comp (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   (comp_out_in),
		.q_out  (comp_s)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_phase_sync
			bdmd_sync u_sync (
				.clk_in (clk_in),
				.rst_in (rst_in),
				.d_in   (gi == 0 ? phase_input_a_in :
				         gi == 1 ? phase_input_b_in : phase_input_c_in),
				.q_out  (ph_s[gi])
			);
		end
	endgenerate

	assign comm      = comm_hw_in | comm_sw_in; // RL13
	assign hall_mode = (speed_input_type_in == TES_POS) && sensor_mode_flag_in; // RL2
	// Demag edge is the opposite level of the zero crossing unless same-edge set
	assign zc_match    = comp_s == edge_polarity_bit_in; // RL11
	assign demag_match = same_edge_select_in ? zc_match : !zc_match; // RL11
	assign zc_tick     = current_mode_in ? meas_window_tick_in : pwm_u_tick_in; // RL7

	// Configuration registers
	always_comb
	begin
		next_blank_code = blank_code;
		next_cnt_limit  = cnt_limit;
		if (demag_filter_wr_in)
		begin
			next_blank_code = demag_blank_window_in;
			next_cnt_limit  = demag_count_limit_in;
		end
	end

	// Demag detection sequencer
	always_comb
	begin
		next_state     = state;
		next_blank_cnt = blank_cnt;
		next_ev_cnt    = ev_cnt;
		next_demag     = demag_flag_out;
		next_zc        = 1'b0;
		case (state)
			BDMD_IDLE:
			begin
				// Zero crossing only once demag seen since commutation
				if (demag_flag_out && zc_tick && zc_match && !comm)
					next_zc = 1'b1; // RL10 RL9
			end
			BDMD_BLANK:
			begin
				if (blank_cnt == '0)
					next_state = BDMD_COUNT; // RL12
				else
					next_blank_cnt = blank_cnt - 1'b1; // RL12
			end
			BDMD_COUNT:
			begin
				if (filter_sample_tick_in) // RL8
				begin
					if (!demag_match)
						next_ev_cnt = '0; // RL20
					else if (ev_cnt + 5'd1 >= {1'b0, cnt_limit} + 5'd1)
					begin
						next_demag = 1'b1; // RL16 RL17
						next_state = BDMD_IDLE;
						next_ev_cnt = '0;
					end
					else
						next_ev_cnt = ev_cnt + 5'd1; // RL16
				end
			end
			default:
				next_state = BDMD_IDLE;
		endcase
		// Simulated demag bypasses the counter
		if (demag_sim_in && state != BDMD_IDLE)
		begin
			next_demag  = 1'b1; // RL19
			next_state  = BDMD_IDLE;
			next_ev_cnt = '0;
		end
		// With speed input type 00, commutation wins over everything: restarts the whole sequence
		if (comm && speed_input_type_in == TES_POS)
		begin
			next_demag  = 1'b0; // RL9
			next_ev_cnt = '0;
			next_zc     = 1'b0;
			if (sensor_mode_flag_in)
			begin
				next_state     = BDMD_COUNT; // RL15
				next_blank_cnt = '0;
			end
			else
			begin
				next_state     = BDMD_BLANK; // RL12 RL13
				next_blank_cnt = blank_cycles(blank_code);
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			blank_code            <= DWF_RESET; // RL18
			cnt_limit             <= DEF_RESET; // RL18
			state                 <= BDMD_IDLE;
			blank_cnt             <= '0;
			ev_cnt                <= '0;
			demag_flag_out        <= 1'b0;
			zero_cross_out        <= 1'b0;
			comp_mux_sel_out      <= PHASE_A;
			comp_enable_out       <= 1'b0;
			comp_int_level_out    <= '0;
			comp_ext_ref_out      <= 1'b0;
			speed_sensor_mode_out <= 1'b0;
			sensor_mode_out       <= 1'b0;
			hall_out              <= '0;
			digital_in_out        <= '0;
		end
		else
		begin
			blank_code            <= next_blank_code;
			cnt_limit             <= next_cnt_limit;
			state                 <= next_state;
			blank_cnt             <= next_blank_cnt;
			ev_cnt                <= next_ev_cnt;
			demag_flag_out        <= next_demag;
			zero_cross_out        <= next_zc;
			comp_mux_sel_out      <= phase_input_select_in; // RL4
			comp_enable_out       <= comp_clk_en_in | ref_dac_en_in; // RL5
			comp_int_level_out    <= threshold_select_in; // RL6
			comp_ext_ref_out      <= threshold_select_in == VR_EXT; // RL6
			speed_sensor_mode_out <= speed_input_type_in != TES_POS; // RL1 RL2
			sensor_mode_out       <= hall_mode; // RL2
			hall_out              <= hall_mode ? ph_s : 3'h0; // RL3
			digital_in_out        <= (speed_input_type_in != TES_POS) ? ph_s : 3'h0; // RL3
		end
	end
endmodule

// *** bdmd_input_detect_sva.sv ***
// Port checker for the demag input detect block.
// Assumes one clock domain; inputs held steady during reset.
module bdmd_input_detect_sva
	import bdmd_pkg::*;
(
	// Clock and reset
	input wire logic       clk_in,
	input wire logic       rst_in,
	// Watched inputs
	input wire logic       sensor_mode_flag_in,
	input wire logic [1:0] speed_input_type_in,
	input wire logic       comp_clk_en_in,
	input wire logic       ref_dac_en_in,
	input wire logic [1:0] phase_input_select_in,
	input wire logic [2:0] threshold_select_in,
	input wire logic       comm_hw_in,
	input wire logic       comm_sw_in,
	// Watched outputs
	input wire logic [1:0] comp_mux_sel_out,
	input wire logic       comp_enable_out,
	input wire logic       comp_ext_ref_out,
	input wire logic       speed_sensor_mode_out,
	input wire logic       sensor_mode_out,
	input wire logic       demag_flag_out,
	input wire logic       zero_cross_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic comm;
	assign comm = (comm_hw_in | comm_sw_in) && speed_input_type_in == TES_POS;
	// Outputs hold reset values one edge after release, so skip that edge
	mux_route_a: assert property (!$past(rst_in) |->
		comp_mux_sel_out == $past(phase_input_select_in)) else $error("mux select wrong");
	comp_on_a: assert property (!$past(rst_in) |->
		comp_enable_out == $past(comp_clk_en_in | ref_dac_en_in))
		else $error("comparator enable wrong");
	ext_ref_a: assert property (!$past(rst_in) |->
		comp_ext_ref_out == $past(threshold_select_in == VR_EXT))
		else $error("external reference wrong");
	speed_mode_a: assert property (!$past(rst_in) |->
		speed_sensor_mode_out == $past(speed_input_type_in != 2'h0))
		else $error("speed sensor mode wrong");
	sensor_sel_a: assert property (!$past(rst_in) |-> sensor_mode_out ==
		$past(sensor_mode_flag_in && speed_input_type_in == TES_POS))
		else $error("sensor mode wrong");
	flag_clear_a: assert property (comm |=> !demag_flag_out)
		else $error("flag not cleared by commutation");
	flag_hold_a: assert property (demag_flag_out && !comm |=> demag_flag_out)
		else $error("flag dropped");
	zc_after_d_a: assert property ($rose(zero_cross_out) |-> $past(demag_flag_out))
		else $error("zero crossing before demag");
	cover property ($rose(demag_flag_out));
	cover property (zero_cross_out);
	cover property (comm ##1 !demag_flag_out);
endmodule
bind bdmd_input_detect bdmd_input_detect_sva chk_u (.clk_in, .rst_in, .sensor_mode_flag_in,
	.speed_input_type_in, .comp_clk_en_in, .ref_dac_en_in, .phase_input_select_in,
	.threshold_select_in, .comm_hw_in, .comm_sw_in, .comp_mux_sel_out, .comp_enable_out,
	.comp_ext_ref_out, .speed_sensor_mode_out, .sensor_mode_out, .demag_flag_out,
	.zero_cross_out);

// *** bdmd_motor_model.sv ***
// Motor windings seen through the phase resistors and comparator.
// Assumes the bench asks for the comparator level; it lags one cycle.
module bdmd_motor_model
(
	// Clock and request
	input  wire logic clk_in,
	input  wire logic level_in,
	// Winding taps and comparator
	output logic      phase_a_out,
	output logic      phase_b_out,
	output logic      phase_c_out,
	output logic      comp_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ang = 8'h00;
	initial comp_out = 1'b1;
	// Rotating pattern so the pins never sit still
	always @(posedge clk_in)
	begin
		ang <= ang + 8'h01;
		comp_out <= level_in;
	end
	assign phase_a_out = ang[7];
	assign phase_b_out = ang[7] ^ ang[6];
	assign phase_c_out = ~ang[7];
endmodule

// *** bdmd_pkg.sv ***
// Constants for the demagnetisation input detection front end.
// Assumes a 50 MHz core clock; blanking times are given for a 4 MHz reference.
package bdmd_pkg;
	localparam int          CLK_HZ          = 50_000_000;
	localparam int          REF_HZ          = 4_000_000;
	localparam int          BLANK_STEP_LO_US = 5;
	localparam int          BLANK_BASE_HI_US = 60;
	localparam int          BLANK_STEP_HI_US = 20;
	localparam int          CYC_PER_US      = CLK_HZ / 1_000_000;
	localparam int          BLANK_W         = 14;
	localparam logic [1:0]  TES_POS         = 2'h0;
	localparam logic [1:0]  PHASE_A         = 2'h0;
	localparam logic [1:0]  PHASE_B         = 2'h1;
	localparam logic [1:0]  PHASE_C         = 2'h2;
	localparam logic [2:0]  VR_EXT          = 3'h7;
	localparam logic [3:0]  DWF_RESET       = 4'hf;
	localparam logic [3:0]  DEF_RESET       = 4'h0;
	localparam int          SYNC_STAGES     = 3;
	typedef enum logic [2:0] {
		BDMD_IDLE  = 3'b001,
		BDMD_BLANK = 3'b010,
		BDMD_COUNT = 3'b100
	} bdmd_state_e;
endpackage

// *** bdmd_sync.sv ***
// Three-stage input synchroniser with second/third stage agreement.
// Assumes asynchronous inputs; output is a registered filtered level.
module bdmd_sync
	import bdmd_pkg::*;
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// Data
	input  wire logic d_in,
	output logic      q_out
);
	logic [SYNC_STAGES-1:0] stage;
	logic                   next_q;

	always_comb
	begin
		next_q = q_out;
		if (stage[1] == stage[2])
			next_q = stage[2];
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			stage <= '0;
			q_out <= 1'b0;
		end
		else
		begin
			stage <= {stage[SYNC_STAGES-2:0], d_in};
			q_out <= next_q;
		end
	end
endmodule

// *** test_bemf_input_demag_detect.sv ***
// Self-checking bench for the demag input detect block.
// Assumes the motor model drives the pins and comparator.
module test_bemf_input_demag_detect;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0, rst_in = 1'b1, sr = 1'b0, wr = 1'b0, chw = 1'b0, csw = 1'b0;
	logic sim = 1'b0, tick = 1'b0, pwm = 1'b0, dm = 1'b1, cke = 1'b0, dac = 1'b0;
	logic [1:0] speed_input_type = 2'h0, sel = 2'h0, mux;
	logic [2:0] thr = 3'h0, tc = 3'h0;
	logic [3:0] bw = 4'h0, lim = 4'h0;
	logic pa, pb, pc, cmp, df, zc, en, ext, spd, sns;
	logic [2:0] lvl, hl, di;
	int n_mismatch = 0, check_count = 0, n;
	logic [15:0] rows [5] = '{16'h0000, 16'h7c5d, 16'hb2aa, 16'h3f4e, 16'h4992};
	initial forever #10 clk_in = ~clk_in;
	// Filter sample tick every 8 cycles
	always @(posedge clk_in)
	begin
		tc <= tc + 3'h1;
		tick <= (tc == 3'h7);
	end
	bdmd_motor_model mdl_u (.clk_in(clk_in), .level_in(dm), .phase_a_out(pa),
		.phase_b_out(pb), .phase_c_out(pc), .comp_out(cmp));
	bdmd_input_detect dut_u (.clk_in(clk_in), .rst_in(rst_in), .phase_input_a_in(pa),
		.phase_input_b_in(pb), .phase_input_c_in(pc), .comp_out_in(cmp),
		.sensor_mode_flag_in(sr), .speed_input_type_in(speed_input_type), .current_mode_in(1'b0),
		.hard_comm_in(1'b1), .comp_clk_en_in(cke), .ref_dac_en_in(dac),
		.phase_input_select_in(sel), .threshold_select_in(thr), .edge_polarity_bit_in(1'b0),
		.same_edge_select_in(1'b0), .demag_filter_wr_in(wr), .demag_blank_window_in(bw),
		.demag_count_limit_in(lim), .comm_hw_in(chw), .comm_sw_in(csw), .demag_sim_in(sim),
		.filter_sample_tick_in(tick), .meas_window_tick_in(1'b0), .pwm_u_tick_in(pwm),
		.comp_mux_sel_out(mux), .comp_enable_out(en), .comp_int_level_out(lvl),
		.comp_ext_ref_out(ext), .speed_sensor_mode_out(spd), .sensor_mode_out(sns),
		.hall_out(hl), .digital_in_out(di), .demag_flag_out(df), .zero_cross_out(zc));
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_in);
	endtask
	task automatic bad(input string m);
		n_mismatch++;
		$display("MISMATCH %0t %s", $time, m);
	endtask
	task automatic chk_val(input logic [5:0] got, input logic [5:0] exp);
		check_count++;
		if (got !== exp)
			bad("output value");
	endtask
	task automatic chk_time(input int t, input int lo, input int hi);
		check_count++;
		if (t < lo || t > hi)
			bad($sformatf("delay %0d", t));
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic comm(input logic s);
		@(posedge clk_in) {csw, chw} <= {s, ~s};
		@(posedge clk_in) {csw, chw} <= 2'h0;
		#1;
	endtask
	// Pins move every 64 cycles; look mid-way so the synchroniser has settled
	task automatic chk_pins(input logic [1:0] t, input logic s);
		logic [2:0] p;
		n = 0;
		while (mdl_u.ang[5:0] != 6'h20 && n < 80)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		p = {pc, pb, pa};
		chk_val({hl, di}, {(t == 2'h0 && s) ? p : 3'h0, (t != 2'h0) ? p : 3'h0});
	endtask
	task automatic load(input logic [3:0] b, input logic [3:0] l);
		@(posedge clk_in) {wr, bw, lim} <= {1'b1, b, l};
		@(posedge clk_in) wr <= 1'b0;
	endtask
	// Bounded wait for the flag; running out ends the run
	task automatic meas(input int bound);
		n = 0;
		while (df !== 1'b1 && n < bound)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		if (df !== 1'b1)
		begin
			bad("flag wait ran out");
			print_verdict();
		end
	endtask
	task automatic zc_probe(input logic exp);
		logic seen;
		seen = 1'b0;
		@(posedge clk_in) pwm <= 1'b1;
		@(posedge clk_in) pwm <= 1'b0;
		repeat (3)
		begin
			#1;
			seen |= (zc === 1'b1);
			@(posedge clk_in);
		end
		chk_val({5'h0, seen}, {5'h0, exp});
	endtask
	initial
	begin
		cyc(4);
		rst_in <= 1'b0;
		foreach (rows[i])
		begin
			@(posedge clk_in) {sel, thr, cke, dac, speed_input_type, sr} <= rows[i][15:6];
			cyc(2);
			#1;
			chk_val({mux, en, ext, spd, sns}, rows[i][5:0]);
			chk_val({3'h0, lvl}, {3'h0, rows[i][13:11]});
			chk_pins(rows[i][8:7], rows[i][6]);
		end
		@(posedge clk_in) {speed_input_type, sr} <= 3'h0;
		comm(1'b0);
		meas(10100);
		chk_time(n, 9995, 10012);
		load(4'h0, 4'h2);
		comm(1'b1);
		meas(400);
		chk_time(n, 266, 277);
		load(4'h0, 4'h3);
		comm(1'b0);
		cyc(266);
		dm <= 1'b0;
		cyc(10);
		dm <= 1'b1;
		meas(100);
		chk_time(n + 276, 298, 322);
		load(4'hf, 4'h0);
		@(posedge clk_in) sr <= 1'b1;
		comm(1'b0);
		meas(50);
		chk_time(n, 1, 12);
		@(posedge clk_in) {sr, dm} <= 2'h0;
		load(4'h0, 4'h0);
		comm(1'b0);
		cyc(20);
		sim <= 1'b1;
		cyc(1);
		sim <= 1'b0;
		meas(4);
		chk_time(n, 0, 3);
		zc_probe(1'b1);
		comm(1'b1);
		zc_probe(1'b0);
		// Mid-run reset with the flag up, then the default window again
		@(posedge clk_in) sim <= 1'b1;
		@(posedge clk_in) sim <= 1'b0;
		@(posedge clk_in) rst_in <= 1'b1;
		cyc(2);
		#1;
		chk_val({5'h0, df}, 6'h0);
		@(posedge clk_in) {rst_in, dm} <= 2'b01;
		comm(1'b0);
		meas(10100);
		chk_time(n, 9995, 10012);
		print_verdict();
	end
endmodule
